// *** uart_shadow_pkg.sv ***
// Shared constants for the UART shadow data port
package uart_shadow_pkg;
   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam logic [31:0] ALIAS_BASE_ADDR   = 32'h5000_1030;
   localparam logic [31:0] ALIAS_SPAN_BYTES  = 32'h0000_0040;
   localparam logic [31:0] ALIAS_2_ADDR      = 32'h5000_1038;
   localparam logic [31:0] ALIAS_3_ADDR      = 32'h5000_103c;
   localparam logic [31:0] CTRL_ADDR         = 32'h5000_1080;
   localparam logic [31:0] LINE_STATUS_ADDR  = 32'h5000_1084;
   localparam logic [31:0] IRQ_STATUS_ADDR   = 32'h5000_1088;
   localparam logic [31:0] IRQ_MASK_ADDR     = 32'h5000_108c;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_FIFO_EN_BIT  = 0;
   localparam int CTRL_IR_MODE_BIT  = 1;
   localparam int LS_DATA_READY_BIT = 0;
   localparam int LS_OVERRUN_BIT    = 1;
   localparam int LS_TX_EMPTY_BIT   = 5;
   localparam int LS_TX_FULL_BIT    = 6;
   localparam int EV_RX_BIT         = 0;
   localparam int EV_OVERRUN_BIT    = 1;
   localparam int EV_TX_EMPTY_BIT   = 2;
   localparam int EV_TX_DROP_BIT    = 3;
   localparam int EV_WIDTH          = 4;

   // ------------------------------------------------------------
   // Reset values and sizes
   // ------------------------------------------------------------
   localparam logic [1:0]  CTRL_RESET       = 2'h0;
   localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;
   localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;
   localparam int          FIFO_DEPTH_RESET = 16;
endpackage : uart_shadow_pkg

// *** uart_shadow_data_port.sv ***
// Shadow data port of a UART: aliased receive/transmit data locations
//
// Behaviour
// - Sixteen aliased 32-bit words all reach the receive buffer and transmit holding.
// - Received byte comes from serial input, or infrared input in infrared mode.
// - Read byte is valid only while data-ready is set; reader checks first.
// - FIFOs off: new character overwrites unread byte and flags overrun.
// - FIFOs on: a read returns the receive FIFO head.
// - Receive FIFO full: keep contents, drop new character, flag overrun.
// - Written data goes to serial output, or active-low infrared output.
// - FIFOs off: one write clears transmit-holding-empty.
// - FIFOs off: further writes before empty replace the pending byte.
// - FIFOs on: writes accepted up to configured depth before full.
// - Write to a full transmit FIFO is dropped, contents unchanged.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module uart_shadow_data_port #(
   parameter int DEPTH = uart_shadow_pkg::FIFO_DEPTH_RESET
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Register port
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        we_i,
   input  wire logic        re_i,
   output logic      [31:0] rdata_o,
   // Receive characters
   input  wire logic        rx_sin_valid_i,
   input  wire logic [7:0]  rx_sin_data_i,
   input  wire logic        rx_sir_valid_i,
   input  wire logic [7:0]  rx_sir_data_i,
   // Transmit characters
   output logic      [7:0]  tx_data_o,
   output logic             tx_sout_valid_o,
   output logic             tx_sir_valid_n_o,
   input  wire logic        tx_ready_i,
   // Interrupt
   output logic             irq_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CAP_FIFO = CW'(DEPTH);
   localparam logic [CW-1:0] CAP_ONE  = CW'(1);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0]             rx_mem [DEPTH];
   logic [7:0]             tx_mem [DEPTH];
   logic [AW-1:0]          rx_rd, rx_wr, tx_rd, tx_wr;
   logic [CW-1:0]          rx_count, tx_count;
   logic [1:0]             ctrl;
   logic                   overrun;
   logic [uart_shadow_pkg::EV_WIDTH-1:0] irq_status, irq_mask;

   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : step

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire [31:0] alias_off  = addr_i - uart_shadow_pkg::ALIAS_BASE_ADDR;
   wire alias_hit         = (alias_off < uart_shadow_pkg::ALIAS_SPAN_BYTES) && (alias_off[1:0] == 2'h0);
   wire rd_alias          = re_i && alias_hit;
   wire wr_alias          = we_i && alias_hit;
   wire ctrl_hit          = addr_i == uart_shadow_pkg::CTRL_ADDR;
   wire lstat_hit         = addr_i == uart_shadow_pkg::LINE_STATUS_ADDR;
   wire istat_hit         = addr_i == uart_shadow_pkg::IRQ_STATUS_ADDR;
   wire imask_hit         = addr_i == uart_shadow_pkg::IRQ_MASK_ADDR;
   wire fifo_en           = ctrl[uart_shadow_pkg::CTRL_FIFO_EN_BIT];
   wire ir_mode           = ctrl[uart_shadow_pkg::CTRL_IR_MODE_BIT];
   // Switching FIFO mode flushes both paths; old pointers mean nothing in the new mode
   wire flush             = we_i && ctrl_hit && (wdata_i[uart_shadow_pkg::CTRL_FIFO_EN_BIT] != fifo_en);
   wire [CW-1:0] cap      = fifo_en ? CAP_FIFO : CAP_ONE;

   // ------------------------------------------------------------
   // Receive path
   // ------------------------------------------------------------
   wire       rx_in_valid = ir_mode ? rx_sir_valid_i : rx_sin_valid_i;
   wire [7:0] rx_in_data  = ir_mode ? rx_sir_data_i : rx_sin_data_i;
   wire [7:0] rx_head     = rx_mem[rx_rd];
   wire rx_ready_flag     = rx_count != '0;
   wire rx_pop            = rd_alias && rx_ready_flag;
   wire rx_full           = (rx_count == cap) && !rx_pop;
   wire rx_overrun        = rx_in_valid && rx_full;
   wire rx_push           = rx_in_valid && !rx_full;
   wire rx_replace        = rx_overrun && !fifo_en;
   wire rx_we             = rx_push || rx_replace;
   wire [AW-1:0] rx_widx  = rx_replace ? rx_rd : rx_wr;
   wire [CW-1:0] next_rx_count = rx_count + CW'(rx_push) - CW'(rx_pop);

   // ------------------------------------------------------------
   // Transmit path
   // ------------------------------------------------------------
   wire tx_empty          = tx_count == '0;
   wire tx_pop            = tx_ready_i && !tx_empty;
   wire tx_full           = (tx_count == cap) && !tx_pop;
   wire tx_push           = wr_alias && !tx_full;
   wire tx_replace        = wr_alias && tx_full && !fifo_en;
   wire tx_drop           = wr_alias && tx_full && fifo_en;
   wire tx_we             = tx_push || tx_replace;
   wire [AW-1:0] tx_widx  = tx_replace ? tx_rd : tx_wr;
   wire [CW-1:0] next_tx_count = tx_count + CW'(tx_push) - CW'(tx_pop);

   assign tx_data_o        = tx_mem[tx_rd];
   assign tx_sout_valid_o  = !tx_empty && !ir_mode;
   assign tx_sir_valid_n_o = !(!tx_empty && ir_mode);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            rx_mem[i] <= 8'h00;
            tx_mem[i] <= 8'h00;
         end else begin
            if (rx_we && rx_widx == AW'(i)) rx_mem[i] <= rx_in_data;
            if (tx_we && tx_widx == AW'(i)) tx_mem[i] <= wdata_i[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Pointers and counts
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || flush) begin
         rx_rd    <= '0;
         rx_wr    <= '0;
         rx_count <= '0;
         tx_rd    <= '0;
         tx_wr    <= '0;
         tx_count <= '0;
      end else begin
         if (rx_pop) rx_rd <= step(rx_rd);
         if (rx_push) rx_wr <= step(rx_wr);
         rx_count <= next_rx_count;
         if (tx_pop) tx_rd <= step(tx_rd);
         if (tx_push) tx_wr <= step(tx_wr);
         tx_count <= next_tx_count;
      end
   end

   // ------------------------------------------------------------
   // Registers and events
   // ------------------------------------------------------------
   // Last byte leaving the store is the moment holding-empty comes back
   wire tx_went_empty = tx_pop && tx_count == CW'(1) && !tx_push;
   logic [uart_shadow_pkg::EV_WIDTH-1:0] events;
   always_comb begin
      events                                   = '0;
      events[uart_shadow_pkg::EV_RX_BIT]       = rx_push;
      events[uart_shadow_pkg::EV_OVERRUN_BIT]  = rx_overrun;
      events[uart_shadow_pkg::EV_TX_EMPTY_BIT] = tx_went_empty;
      events[uart_shadow_pkg::EV_TX_DROP_BIT]  = tx_drop;
   end
   wire [uart_shadow_pkg::EV_WIDTH-1:0] clr_bits =
      (we_i && istat_hit) ? wdata_i[uart_shadow_pkg::EV_WIDTH-1:0] : '0;
   logic [7:0] line_status;
   always_comb begin
      line_status                                     = 8'h00;
      line_status[uart_shadow_pkg::LS_DATA_READY_BIT] = rx_ready_flag;
      line_status[uart_shadow_pkg::LS_OVERRUN_BIT]    = overrun;
      line_status[uart_shadow_pkg::LS_TX_EMPTY_BIT]   = tx_empty;
      line_status[uart_shadow_pkg::LS_TX_FULL_BIT]    = tx_full;
   end

   logic [31:0] read_mux;
   always_comb begin
      read_mux = 32'h0;
      if (alias_hit)      read_mux = {24'h0, rx_head};
      else if (ctrl_hit)  read_mux = {30'h0, ctrl};
      else if (lstat_hit) read_mux = {24'h0, line_status};
      else if (istat_hit) read_mux = {28'h0, irq_status};
      else if (imask_hit) read_mux = {28'h0, irq_mask};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl       <= uart_shadow_pkg::CTRL_RESET;
         irq_mask   <= uart_shadow_pkg::IRQ_MASK_RESET;
         irq_status <= '0;
         overrun    <= 1'b0;
         rdata_o    <= uart_shadow_pkg::RDATA_RESET;
      end else begin
         if (we_i && ctrl_hit) ctrl <= wdata_i[1:0];
         if (we_i && imask_hit) irq_mask <= wdata_i[uart_shadow_pkg::EV_WIDTH-1:0];
         // Set wins over a clear in the same cycle
         irq_status <= (irq_status & ~clr_bits) | events;
         overrun    <= rx_overrun || (overrun && !(re_i && lstat_hit));
         rdata_o    <= re_i ? read_mux : 32'h0;
      end
   end

   assign irq_o = |(irq_status & irq_mask);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   rdata_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !re_i |=> rdata_o == 32'h0)
      else $error("read data not zero outside read answer");

   head_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_alias && rx_ready_flag |=> rdata_o == {24'h0, $past(rx_head)})
      else $error("alias read did not return receive head");

   ir_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ir_mode && rx_sir_valid_i && rx_count == '0 && !flush && !rd_alias
      |=> rx_count == CW'(1) && rx_head == $past(rx_sir_data_i))
      else $error("infrared byte not captured in infrared mode");

   ready_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_push && !flush
      |=> line_status[uart_shadow_pkg::LS_DATA_READY_BIT] && irq_status[uart_shadow_pkg::EV_RX_BIT])
      else $error("data ready not set after capture");

   rx_overwrite_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !fifo_en && rx_count == CW'(1) && rx_in_valid && !rd_alias && !flush
      |=> rx_count == CW'(1) && overrun && rx_head == $past(rx_in_data))
      else $error("single buffer did not overwrite with overrun");

   rx_keep_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fifo_en && rx_overrun && !flush
      |=> $stable(rx_count) && $stable(rx_head) && overrun && irq_status[uart_shadow_pkg::EV_OVERRUN_BIT])
      else $error("full receive FIFO changed on overrun");

   tx_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_count != '0 |-> (ir_mode ? (!tx_sir_valid_n_o && !tx_sout_valid_o)
                                  : (tx_sout_valid_o && tx_sir_valid_n_o)))
      else $error("transmit data on wrong output");

   tx_holding_empty_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !fifo_en && tx_empty && wr_alias && !flush
      |=> !line_status[uart_shadow_pkg::LS_TX_EMPTY_BIT] && tx_data_o == $past(wdata_i[7:0]))
      else $error("write did not clear transmit empty");

   tx_replace_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !fifo_en && tx_count == CW'(1) && wr_alias && !tx_ready_i && !flush
      |=> tx_count == CW'(1) && tx_data_o == $past(wdata_i[7:0]))
      else $error("pending transmit byte not replaced");

   tx_fill_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fifo_en && tx_count < CAP_FIFO && wr_alias && !tx_ready_i && !flush
      |=> tx_count == $past(tx_count) + CW'(1))
      else $error("transmit FIFO refused a write below depth");

   tx_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_drop && !flush |=> $stable(tx_count) && $stable(tx_data_o) && irq_status[uart_shadow_pkg::EV_TX_DROP_BIT])
      else $error("write into full transmit FIFO was not dropped");

   alias_pop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_alias && rx_ready_flag && !rx_in_valid && !flush |=> rx_count == $past(rx_count) - CW'(1))
      else $error("alias read did not pop receive data");

   sin_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ir_mode && rx_sin_valid_i && !rx_sir_valid_i && !rd_alias && !flush |=> $stable(rx_count))
      else $error("serial input taken in infrared mode");

   sir_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !ir_mode && rx_sir_valid_i && !rx_sin_valid_i && !rd_alias && !flush |=> $stable(rx_count))
      else $error("infrared input taken in serial mode");

   empty_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_alias && !rx_ready_flag && !rx_in_valid && !flush |=> rx_count == '0)
      else $error("read of empty receive store changed its count");

   rx_fill_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fifo_en && rx_in_valid && rx_count < CAP_FIFO && !rd_alias && !flush
      |=> rx_count == $past(rx_count) + CW'(1))
      else $error("receive FIFO refused a character below depth");

   overrun_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_overrun |=> overrun && irq_status[uart_shadow_pkg::EV_OVERRUN_BIT])
      else $error("overrun not flagged");

   overrun_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      re_i && lstat_hit && !rx_overrun |=> !overrun)
      else $error("overrun flag survived a status read");

   tx_pop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_ready_i && tx_count != '0 && !wr_alias && !flush |=> tx_count == $past(tx_count) - CW'(1))
      else $error("taken transmit byte not removed");

   tx_full_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fifo_en && tx_count == CAP_FIFO && !tx_ready_i |-> line_status[uart_shadow_pkg::LS_TX_FULL_BIT])
      else $error("transmit FIFO at depth not reported full");

   tx_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_count == '0 |-> !tx_sout_valid_o && tx_sir_valid_n_o)
      else $error("transmit output valid with nothing pending");

   tx_holding_empty_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_pop && tx_count == CW'(1) && !wr_alias && !flush
      |=> line_status[uart_shadow_pkg::LS_TX_EMPTY_BIT] && irq_status[uart_shadow_pkg::EV_TX_EMPTY_BIT])
      else $error("holding empty not restored after last byte left");

   irq_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      we_i && istat_hit && wdata_i[uart_shadow_pkg::EV_TX_EMPTY_BIT] && !tx_went_empty
      |=> !irq_status[uart_shadow_pkg::EV_TX_EMPTY_BIT])
      else $error("written one did not clear transmit empty event");

   flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
      flush |=> rx_count == '0 && tx_count == '0)
      else $error("fifo mode change did not empty both paths");
endmodule : uart_shadow_data_port

// *** line_partner.sv ***
// Line-side partner model that takes transmit bytes
`timescale 1ns/1ps
module line_partner (
   // Clock
   input  wire logic       clk_i,
   // Bench control
   input  wire logic       stall_i,
   // Transmit side of the block
   input  wire logic [7:0] tx_data_i,
   input  wire logic       sout_valid_i,
   input  wire logic       sir_valid_n_i,
   output logic            tx_ready_o,
   // Observed traffic
   output logic      [7:0] last_o,
   output logic      [7:0] count_o
);
   // Stalling lets the bench pile up bytes in the block
   assign tx_ready_o = ~stall_i;
   logic [7:0] last  = 8'h00;
   logic [7:0] count = 8'h00;
   assign last_o  = last;
   assign count_o = count;
   // A byte leaves on either line; the infrared valid is active low
   always @(posedge clk_i) begin
      if (tx_ready_o && (sout_valid_i || !sir_valid_n_i)) begin
         last  <= tx_data_i;
         count <= count + 8'h01;
      end
   end
endmodule : line_partner

// *** testbench.sv ***
// Self-checking bench for the UART shadow data port
`timescale 1ns/1ps
module testbench;
   logic clk_i, rst_i, we_i, re_i, sv, iv, stall;
   logic [31:0] addr_i, wdata_i, rdata_o, r;
   logic [7:0] sd, id, tx_data_o, last, cnt;
   logic tx_sout_valid_o, tx_sir_valid_n_o, tx_ready_i, irq_o;
   int errors, n_checks;
   localparam logic [31:0] full_word = 32'hffff_ffff;
   uart_shadow_data_port #(.DEPTH(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .rx_sin_valid_i(sv),
      .rx_sin_data_i(sd), .rx_sir_valid_i(iv), .rx_sir_data_i(id), .tx_data_o(tx_data_o),
      .tx_sout_valid_o(tx_sout_valid_o), .tx_sir_valid_n_o(tx_sir_valid_n_o),
      .tx_ready_i(tx_ready_i), .irq_o(irq_o));
   line_partner PARTNER (.clk_i(clk_i), .stall_i(stall), .tx_data_i(tx_data_o),
      .sout_valid_i(tx_sout_valid_o), .sir_valid_n_i(tx_sir_valid_n_o),
      .tx_ready_o(tx_ready_i), .last_o(last), .count_o(cnt));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i) begin we_i <= 1'b1; addr_i <= a; wdata_i <= d; end
      @(posedge clk_i) we_i <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [31:0] a);
      @(posedge clk_i) begin re_i <= 1'b1; addr_i <= a; end
      @(posedge clk_i) re_i <= 1'b0;
      #1 r = rdata_o;
   endtask : rd
   task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      rd(a);
      chk(name, exp, r & m);
   endtask : rd_chk
   task automatic rx(input logic vs, input logic [7:0] s, input logic vi, input logic [7:0] i);
      @(posedge clk_i) begin sv <= vs; sd <= s; iv <= vi; id <= i; end
      @(posedge clk_i) begin sv <= 1'b0; iv <= 1'b0; end
   endtask : rx
   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic rx_single;
      rx(1'b1, 8'h55, 1'b0, 8'h00);
      rd_chk("ready", uart_shadow_pkg::LINE_STATUS_ADDR, 32'h1, 32'h1);
      rd_chk("rx 55", uart_shadow_pkg::ALIAS_2_ADDR, full_word, 32'h55);
      rx(1'b1, 8'h66, 1'b0, 8'h00);
      rx(1'b1, 8'h77, 1'b0, 8'h00);
      rd_chk("overrun", uart_shadow_pkg::LINE_STATUS_ADDR, 32'h2, 32'h2);
      rd_chk("rx 77", uart_shadow_pkg::ALIAS_3_ADDR, full_word, 32'h77);
      wr(uart_shadow_pkg::CTRL_ADDR, 32'h2);
      rx(1'b1, 8'h01, 1'b1, 8'ha3);
      rd_chk("rx ir", uart_shadow_pkg::ALIAS_2_ADDR, full_word, 32'ha3);
   endtask : rx_single
   task automatic rx_fifo;
      wr(uart_shadow_pkg::CTRL_ADDR, 32'h1);
      rx(1'b1, 8'h10, 1'b0, 8'h00);
      rx(1'b1, 8'h20, 1'b0, 8'h00);
      rx(1'b1, 8'h30, 1'b0, 8'h00);
      rd_chk("fifo ovr", uart_shadow_pkg::LINE_STATUS_ADDR, 32'h2, 32'h2);
      rd_chk("head 10", 32'h5000_1030, full_word, 32'h10);
      rd_chk("head 20", 32'h5000_106c, full_word, 32'h20);
      rd_chk("empty", uart_shadow_pkg::LINE_STATUS_ADDR, 32'h1, 32'h0);
      rd_chk("unmapped", 32'h5000_1000, full_word, 32'h0);
   endtask : rx_fifo
   task automatic tx_single;
      wr(uart_shadow_pkg::CTRL_ADDR, 32'h0);
      stall <= 1'b1;
      rd_chk("tx_holding_empty", uart_shadow_pkg::LINE_STATUS_ADDR, 32'h20, 32'h20);
      wr(uart_shadow_pkg::ALIAS_2_ADDR, 32'h41);
      rd_chk("tx_holding_empty off", uart_shadow_pkg::LINE_STATUS_ADDR, 32'h20, 32'h0);
      wr(uart_shadow_pkg::ALIAS_3_ADDR, 32'h42);
      #1 chk("sout", 32'h1, {31'h0, tx_sout_valid_o});
      stall <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("tx last", 32'h42, {24'h0, last});
      chk("tx cnt", 32'h1, {24'h0, cnt});
      wr(uart_shadow_pkg::IRQ_MASK_ADDR, 32'h4);
      #1 chk("irq on", 32'h1, {31'h0, irq_o});
      wr(uart_shadow_pkg::IRQ_STATUS_ADDR, 32'h4);
      #1 chk("irq off", 32'h0, {31'h0, irq_o});
   endtask : tx_single
   task automatic tx_fifo;
      wr(uart_shadow_pkg::CTRL_ADDR, 32'h3);
      stall <= 1'b1;
      wr(32'h5000_1030, 32'h11);
      #1 chk("sir", 32'h0, {31'h0, tx_sir_valid_n_o});
      chk("sout ir", 32'h0, {31'h0, tx_sout_valid_o});
      wr(32'h5000_1034, 32'h22);
      wr(32'h5000_106c, 32'h33);
      rd_chk("full", uart_shadow_pkg::LINE_STATUS_ADDR, 32'h40, 32'h40);
      rd_chk("drop", uart_shadow_pkg::IRQ_STATUS_ADDR, 32'h8, 32'h8);
      stall <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("fifo last", 32'h22, {24'h0, last});
      chk("fifo cnt", 32'h3, {24'h0, cnt});
   endtask : tx_fifo
   // ------------------------------------------------------------
   // Clock, reset, sequence, watchdog
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      #200000 errors++;
      close_out();
   end
   initial begin
      {we_i, re_i, sv, iv, stall} = '0;
      {addr_i, wdata_i, sd, id} = '0;
      errors = 0;
      n_checks = 0;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk("reset", uart_shadow_pkg::ALIAS_2_ADDR, full_word, 32'h0);
      rx_single();
      rx_fifo();
      tx_single();
      tx_fifo();
      close_out();
   end
endmodule : testbench
